// ---- core/external_bus_status_control.sv ----
// external bus status, hold handshake, wait-done and clock output logic
`timescale 1ns/100ps
`default_nettype none
`include "ebsc_map.svh"

module external_bus_status_control
  import ebsc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // pins from outside, asynchronous
  input  wire logic        holdRequest_n,
  input  wire logic        ready,
  input  wire logic        outputFloat_n,
  // access requests from the cpu core
  input  wire logic        accessReq,
  input  wire access_req_t accessInfo,
  // clock output ratio field of bank_switch_ctrl
  input  wire logic        bankSwitchCtrlLoad,
  input  wire logic [1:0]  bankSwitchCtrlRatio,
  // answers to the cpu core
  output var  logic        accessAccept,
  output var  logic        accessDone,
  output var  logic        accessBusy,
  // float command for address, data and control drivers
  output var  logic        busRelease,
  // three-state status pins
  output var  pin_drive_t  bus_grant_ack_n,
  output var  pin_drive_t  wait_states_done_n,
  output var  pin_drive_t  instr_fetch_flag_n,
  output var  pin_drive_t  divided_cycle_clock_out
);

  // ==========================================================
  // input synchronisers
  // ==========================================================

  logic holdMeta;
  logic holdSync_n;
  logic readyMeta;
  logic readySync;
  logic floatMeta;
  logic floatSync_n;

  // two flops per pin; high after reset, the inactive level of all but ready
  always_ff @(posedge core_clk) begin
    if (reset) begin
      holdMeta    <= 1'b1;
      holdSync_n  <= 1'b1;
      readyMeta   <= 1'b1;
      readySync   <= 1'b1;
      floatMeta   <= 1'b1;
      floatSync_n <= 1'b1;
    end else begin
      holdMeta    <= holdRequest_n;
      holdSync_n  <= holdMeta;
      readyMeta   <= ready;
      readySync   <= readyMeta;
      floatMeta   <= outputFloat_n;
      floatSync_n <= floatMeta;
    end
  end

  // ==========================================================
  // machine cycle enable
  // ==========================================================

  logic [`EBSC_CYCLE_CNT_W-1:0] cycleCount;

  // the sequencer steps once per machine cycle, not per core clock
  wire cycleEn = (cycleCount == `EBSC_CYCLE_CNT_W'(`EBSC_CYCLE_DIV - 1));

  // machine cycle prescaler
  always_ff @(posedge core_clk) begin
    if (reset || cycleEn) begin
      cycleCount <= '0;
    end else begin
      cycleCount <= cycleCount + `EBSC_CYCLE_CNT_W'(1);
    end
  end

  // ==========================================================
  // access sequencer
  // ==========================================================

  bus_state_t                state;
  bus_state_t                next_state;
  access_req_t               held;
  logic [`EBSC_WAIT_W-1:0]   waitIndex;
  logic [`EBSC_WAIT_W-1:0]   next_waitIndex;

  // request as seen at the start of a cycle
  wire holdWanted   = ~holdSync_n;
  wire newAccess    = accessReq && !holdWanted;
  wire noWaits      = (held.waitStates == '0);
  wire lastWait     = (waitIndex == held.waitStates);
  // ready is only checked when enough wait states are programmed
  wire readyChecked = (held.waitStates >= `EBSC_MIN_READY_WAITS);
  wire finishAddr   = (state == ST_ADDR) && noWaits;
  // ready is first sampled as the last wait ends, so a wait-done fed
  // back still reads low there and costs exactly one external wait
  wire finishWaits  = (state == ST_SWWAIT) && lastWait &&
                      (!readyChecked || readySync);
  // ready low means one more machine cycle, then sample again
  wire finishReady  = (state == ST_READY) && readySync;
  wire finishing    = cycleEn && (finishAddr || finishWaits || finishReady);
  wire accepting    = cycleEn && (state == ST_IDLE) && newAccess;

  // next state, only applied on a machine cycle boundary
  always_comb begin
    next_state     = state;
    next_waitIndex = waitIndex;
    case (state)
      ST_IDLE: begin
        // hold is granted only between accesses
        if (holdWanted) begin
          next_state = ST_HOLD;
        end else if (accessReq) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (noWaits) begin
          next_state = ST_IDLE;
        end else begin
          next_state     = ST_SWWAIT;
          next_waitIndex = `EBSC_WAIT_W'(1);
        end
      end
      ST_SWWAIT: begin
        if (!lastWait) begin
          next_waitIndex = waitIndex + `EBSC_WAIT_W'(1);
        end else if (readyChecked && !readySync) begin
          next_state = ST_READY;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_READY: begin
        if (readySync) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        // stay floated until the request goes away
        if (!holdWanted) begin
          next_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        // one cycle of driven lines before any new access
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state     <= ST_IDLE;
      waitIndex <= '0;
    end else if (cycleEn) begin
      state     <= next_state;
      waitIndex <= next_waitIndex;
    end
  end

  // request capture; the core keeps accessInfo stable with accessReq
  always_ff @(posedge core_clk) begin
    if (reset) begin
      held <= '0;
    end else if (accepting) begin
      held <= accessInfo;
    end
  end

  // ==========================================================
  // status decode for the next cycle
  // ==========================================================

  // wait-done is low from the start of the first wait state to the
  // start of the last; with fewer than two waits it never moves
  wire nextInWait   = (next_state == ST_SWWAIT) && (state != ST_HOLD);
  wire waitDoneLow  = nextInWait && readyChecked &&
                      (next_waitIndex != held.waitStates);
  // a fetch address sits on the bus from address phase to completion
  wire fetchOnBus   = held.fetch &&
                      ((next_state == ST_ADDR) ||
                       (next_state == ST_SWWAIT) ||
                       (next_state == ST_READY));
  wire fetchStarts  = accessInfo.fetch && (next_state == ST_ADDR);
  wire nextFetchLow = (state == ST_IDLE) ? fetchStarts : fetchOnBus;
  wire nextHold     = (next_state == ST_HOLD);
  wire nextBusy     = (next_state == ST_ADDR) ||
                      (next_state == ST_SWWAIT) ||
                      (next_state == ST_READY);
  // all status pins float together while the float pin is low
  wire floatAll_n   = floatSync_n;

  // ==========================================================
  // registered outputs to the core and bus drivers
  // ==========================================================

  // pulses and levels toward the core and the bus drivers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      accessAccept <= 1'b0;
      accessDone   <= 1'b0;
      accessBusy   <= 1'b0;
      busRelease   <= 1'b0;
    end else begin
      accessAccept <= accepting && newAccess;
      accessDone   <= finishing;
      if (cycleEn) begin
        accessBusy <= nextBusy;
        busRelease <= nextHold;
      end
    end
  end

  // ==========================================================
  // three-state status pins
  // ==========================================================

  // hold grant: high and driven in reset, low in hold
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_grant_ack_n.value    <= 1'b1;
      bus_grant_ack_n.enable_n <= 1'b0;
    end else begin
      if (cycleEn) begin
        bus_grant_ack_n.value <= ~nextHold;
      end
      bus_grant_ack_n.enable_n <= ~floatAll_n;
    end
  end

  // wait-done; when fed back to ready the high edge at the last wait
  // reaches the ready sample late, which costs one external wait
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_states_done_n.value    <= 1'b1;
      wait_states_done_n.enable_n <= 1'b0;
    end else begin
      if (cycleEn) begin
        wait_states_done_n.value <= ~waitDoneLow;
      end
      wait_states_done_n.enable_n <= ~floatAll_n;
    end
  end

  // instruction fetch flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      instr_fetch_flag_n.value    <= 1'b1;
      instr_fetch_flag_n.enable_n <= 1'b0;
    end else begin
      if (cycleEn) begin
        instr_fetch_flag_n.value <= ~nextFetchLow;
      end
      instr_fetch_flag_n.enable_n <= ~floatAll_n;
    end
  end

  // ==========================================================
  // clock output
  // ==========================================================

  logic dividedClock;

  // ratio of 1 to 4 taken from the bank switch control field
  clock_out_divider clockDivider (
    .core_clk  (core_clk),
    .reset     (reset),
    .ratioLoad (bankSwitchCtrlLoad),
    .ratio     (bankSwitchCtrlRatio),
    .clockOut  (dividedClock)
  );

  // retimed once so the pin comes from a flop of this module; the
  // float enable follows the same pin as the status outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      divided_cycle_clock_out.value    <= 1'b0;
      divided_cycle_clock_out.enable_n <= 1'b0;
    end else begin
      divided_cycle_clock_out.value    <= dividedClock;
      divided_cycle_clock_out.enable_n <= ~floatAll_n;
    end
  end

endmodule
`default_nettype wire

// ---- core/ebsc_map.svh ----
// constants of the external bus status and handshake block
`ifndef EBSC_MAP_SVH
`define EBSC_MAP_SVH

// core clocks per machine cycle; the clock output divider assumes two
`define EBSC_CYCLE_DIV        2
// width of the machine cycle prescaler count
`define EBSC_CYCLE_CNT_W      1
// reset value of the clock output ratio field (ratio minus one: divide by 4)
`define EBSC_CLKDIV_RESET     2'h3
// fewest software wait states for which wait-done and ready act
`define EBSC_MIN_READY_WAITS  3'h2
// width of the software wait state count
`define EBSC_WAIT_W           3
// width of the clock output ratio field
`define EBSC_RATIO_W          2

`endif

// ---- core/ebsc_pkg.sv ----
// types shared by the external bus status and handshake block
`default_nettype none
package ebsc_pkg;

  // machine cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SWWAIT,
    ST_READY,
    ST_HOLD,
    ST_RESUME
  } bus_state_t;

  // one external access asked for by the cpu core
  typedef struct packed {
    logic       fetch;
    logic [2:0] waitStates;
  } access_req_t;

  // a three-state pin: level and active-low output enable
  typedef struct packed {
    logic value;
    logic enable_n;
  } pin_drive_t;

endpackage
`default_nettype wire

// ---- core/clock_out_divider.sv ----
// clock output divider: machine-cycle rate divided by 1 to 4
`timescale 1ns/100ps
`default_nettype none
`include "ebsc_map.svh"

module clock_out_divider (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // ratio select, ratio minus one
  input  wire logic       ratioLoad,
  input  wire logic [1:0] ratio,
  // divided clock level
  output var  logic       clockOut
);

  logic [1:0] ratioHeld;
  logic [1:0] halfCount;
  logic [1:0] pendingRatio;
  logic       pendingLoad;

  // half period is ratio+1 core clocks, so a full period is ratio+1
  // machine cycles when a machine cycle is two core clocks
  wire halfDone = (halfCount == ratioHeld);

  // a new ratio is only taken at a falling edge of the output, which
  // keeps the output free of runt pulses when software changes it
  wire takeRatio = halfDone && clockOut && pendingLoad;

  // ratio register, reset to divide by 4
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ratioHeld    <= `EBSC_CLKDIV_RESET;
      pendingRatio <= `EBSC_CLKDIV_RESET;
      pendingLoad  <= 1'b0;
    end else begin
      if (ratioLoad) begin
        pendingRatio <= ratio;
        pendingLoad  <= 1'b1;
      end else if (takeRatio) begin
        pendingLoad <= 1'b0;
      end
      if (takeRatio) begin
        ratioHeld <= pendingRatio;
      end
    end
  end

  // half period counter and output toggle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      halfCount <= 2'h0;
      clockOut  <= 1'b0;
    end else if (halfDone) begin
      halfCount <= 2'h0;
      clockOut  <= ~clockOut;
    end else begin
      halfCount <= halfCount + 2'h1;
    end
  end

endmodule
`default_nettype wire

// ---- verification/ebsc_partner.sv ----
// far-side model: ready source of the external memory or i/o device
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// ready responder
module ebsc_partner
  import ebsc_pkg::*;
(
  // clock and behaviour select
  input  wire logic       core_clk,
  input  wire logic [1:0] mode,
  // wait-done pin seen from outside, ready pin back
  input  wire pin_drive_t waitDone,
  output var  logic       ready
);
  logic [3:0] stall = 4'h0;
  logic       noise = 1'b0;
  logic       slowReady;

  // slow device: ready stays low while wait-done is low and 8 clocks after
  always @(posedge core_clk) begin
    noise <= ~noise;
    if (mode == 2'h2 && !waitDone.value) begin
      stall <= 4'h8;
    end else begin
      stall <= stall - {3'h0, |stall};
    end
  end
  assign slowReady = ~|stall;
  // mode 1 is a plain wire, so a floated wait-done gives a changing level
  assign ready = (mode != 2'h1) ? slowReady :
                 waitDone.enable_n ? noise : waitDone.value;
endmodule
`default_nettype wire

// ---- verification/ebsc_checker.sv ----
// concurrent checks on the ports of the bus status block
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker
module ebsc_checker
  import ebsc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        ready,
  input wire logic        outputFloat_n,
  input wire access_req_t accessInfo,
  input wire logic        bankSwitchCtrlLoad,
  input wire logic [1:0]  bankSwitchCtrlRatio,
  input wire logic        accessAccept,
  input wire logic        accessDone,
  input wire logic        busRelease,
  input wire pin_drive_t  bus_grant_ack_n,
  input wire pin_drive_t  wait_states_done_n,
  input wire pin_drive_t  instr_fetch_flag_n,
  input wire pin_drive_t  divided_cycle_clock_out
);
  logic [2:0] waitsSeen;
  logic [3:0] lowCnt;
  logic [1:0] ratioHeld;
  logic [4:0] sinceLoad;
  logic [3:0] halfCnt;
  logic       lastClk;
  logic       clkEdge;

  assign clkEdge = divided_cycle_clock_out.value != lastClk;
  // history of the access and divider; skips 21 clocks after a ratio load
  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitsSeen <= 3'h0;
      lowCnt <= 4'h0;
      ratioHeld <= 2'h3;
      sinceLoad <= 5'h0;
      halfCnt <= 4'h0;
      lastClk <= 1'b0;
    end else begin
      if (accessAccept) waitsSeen <= accessInfo.waitStates;
      lowCnt <= wait_states_done_n.value ? 4'h0 : lowCnt + 4'h1;
      if (bankSwitchCtrlLoad) ratioHeld <= bankSwitchCtrlRatio;
      sinceLoad <= bankSwitchCtrlLoad ? 5'h0 : sinceLoad + {4'h0, ~&sinceLoad};
      halfCnt <= clkEdge ? 4'h1 : halfCnt + 4'h1;
      lastClk <= divided_cycle_clock_out.value;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence floated;
    !outputFloat_n [*3];
  endsequence
  sequence waitOpened;
    $fell(wait_states_done_n.value);
  endsequence

  a_grant_reset: assert property (disable iff (1'b0)
    reset |=> bus_grant_ack_n == 2'h2) else $error("grant not high in reset");
  a_grant_float: assert property (floated |=> bus_grant_ack_n.enable_n)
    else $error("grant pin not floated");
  a_wait_float: assert property (floated |=> wait_states_done_n.enable_n)
    else $error("wait-done pin not floated");
  a_fetch_float: assert property (floated |=> instr_fetch_flag_n.enable_n)
    else $error("fetch pin not floated");
  a_fetch_marked: assert property (accessAccept |->
    instr_fetch_flag_n.value == !accessInfo.fetch) else $error("fetch flag");
  a_wait_start: assert property (waitOpened |->
    $past(accessAccept, 2) && waitsSeen >= 3'h2) else $error("wait-done early");
  a_wait_length: assert property ($rose(wait_states_done_n.value) |->
    lowCnt == 2 * (waitsSeen - 3'h1)) else $error("wait-done length");
  a_ready_stall: assert property ((waitsSeen >= 3'h2 && !ready) [*5]
    |-> !accessDone) else $error("done while not ready");
  a_clock_half: assert property (clkEdge && sinceLoad > 5'h14 |->
    halfCnt == {2'h0, ratioHeld} + 4'h1) else $error("clock half period");
  a_hold_grant: assert property (busRelease == !bus_grant_ack_n.value)
    else $error("grant and release disagree");
  a_resume_gap: assert property ($fell(busRelease) |-> !accessAccept [*2])
    else $error("access right after hold");
endmodule

bind external_bus_status_control ebsc_checker ebsc_checker_i (.*);
`default_nettype wire

// ---- verification/test_external_bus_status_control.sv ----
// self-checking bench of the bus status and handshake block
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench top
module test_external_bus_status_control
  import ebsc_pkg::*;
;
  logic        core_clk, reset, holdRequest_n, ready, outputFloat_n;
  logic        accessReq, bankSwitchCtrlLoad, f;
  logic [1:0]  bankSwitchCtrlRatio, mode;
  logic [2:0]  w;
  access_req_t accessInfo;
  logic        accessAccept, accessDone, accessBusy, busRelease;
  pin_drive_t  bus_grant_ack_n, wait_states_done_n;
  pin_drive_t  instr_fetch_flag_n, divided_cycle_clock_out;
  int          errTotal = 0, testsRun = 0, cyc = 0, lat, n, base, i;

  external_bus_status_control external_bus_status_control_i (.*);
  ebsc_partner ebsc_partner_i (.core_clk(core_clk), .mode(mode),
    .waitDone(wait_states_done_n), .ready(ready));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reportAndStop();
    if (errTotal == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // later accesses are timed against a prompt two-wait access
  function automatic logic [7:0] expLat(int waits, int extra);
    return 8'(base + 2 * (waits - 2) + 2 * extra);
  endfunction

  task automatic request(input logic fe, input logic [2:0] ws, output int k);
    @(posedge core_clk);
    accessReq <= 1'b1;
    accessInfo <= '{fe, ws};
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (accessAccept !== 1'b1 && k < 60);
    check(instr_fetch_flag_n.value, !fe);
    check({busRelease, bus_grant_ack_n.value, accessBusy}, 8'h3);
  endtask

  task automatic finish(output int k);
    @(posedge core_clk);
    accessReq <= 1'b0;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (accessDone !== 1'b1 && k < 60);
    check({accessBusy, instr_fetch_flag_n.value}, 8'h1);
  endtask

  task automatic access(input logic fe, input logic [2:0] ws, output int k);
    request(fe, ws, k);
    finish(k);
  endtask

  // skips to one clock output change, then counts to the next
  task automatic half(output int k);
    logic v;
    @(negedge core_clk);
    repeat (2) begin
      v = divided_cycle_clock_out.value;
      k = 0;
      while (divided_cycle_clock_out.value === v && k < 20) begin
        @(negedge core_clk);
        k++;
      end
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // the whole run needs under 1000 clocks
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errTotal++;
      reportAndStop();
    end
  end

  initial begin
    {reset, holdRequest_n, outputFloat_n} = 3'h7;
    {accessReq, bankSwitchCtrlLoad, bankSwitchCtrlRatio, mode} = 6'h0;
    accessInfo = '0;
    void'($urandom(32'heebb));
    @(negedge core_clk);
    check(bus_grant_ack_n, 8'h2);
    @(posedge core_clk);
    reset <= 1'b0;
    half(lat);
    check(8'(lat), 8'h4);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      bankSwitchCtrlLoad <= 1'b1;
      bankSwitchCtrlRatio <= 2'(i);
      @(posedge core_clk);
      bankSwitchCtrlLoad <= 1'b0;
      repeat (20) @(posedge core_clk);
      half(lat);
      check(8'(lat), 8'(i + 1));
    end
    access(1'b0, 3'h2, base);
    access(1'b1, 3'h0, lat);
    access(1'b0, 3'h1, lat);
    for (i = 0; i < 10; i++) begin
      w = 3'($urandom_range(2, 7));
      f = 1'($urandom);
      access(f, w, lat);
      check(8'(lat), expLat(w, 0));
    end
    // wait-done wired to ready, then a slow device
    @(posedge core_clk);
    mode <= 2'h1;
    access(1'b0, 3'h2, lat);
    check(8'(lat), expLat(2, 1));
    @(posedge core_clk);
    mode <= 2'h2;
    access(1'b1, 3'h3, lat);
    check(8'(lat > int'(expLat(3, 0))), 8'h1);
    @(posedge core_clk);
    mode <= 2'h0;
    // hold taken first; the access must wait until it is withdrawn
    @(posedge core_clk);
    holdRequest_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(bus_grant_ack_n.value, 8'h0);
    fork
      request(1'b0, 3'h2, n);
      begin
        repeat (14) @(posedge core_clk);
        holdRequest_n <= 1'b1;
      end
    join
    check(8'(n > 14), 8'h1);
    finish(lat);
    @(posedge core_clk);
    outputFloat_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check({bus_grant_ack_n.enable_n, wait_states_done_n.enable_n,
           instr_fetch_flag_n.enable_n,
           divided_cycle_clock_out.enable_n}, 8'hf);
    @(posedge core_clk);
    outputFloat_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    reportAndStop();
  end
endmodule
`default_nettype wire
